// File: test_vee_event_enable.sv
// Purpose: Self-checking bench for the event enable block.
// Assumes: Inputs change at the falling edge; reads answer next cycle.
// Notes:   Expected reads and notes wait in queues for the monitor.
`timescale 1ns/1ps
`default_nettype none
module test_vee_event_enable;
  logic                   clock_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   reg_write_i = 1'b0;
  logic                   reg_read_i = 1'b0;
  logic [7:0]             reg_addr_i = 8'h00;
  logic [7:0]             reg_wdata_i = 8'h00;
  logic [7:0]             reg_rdata_o;
  vee_pkg::vee_sense_type sense = '0;
  logic                   sess = 1'b0;
  logic                   resk = 1'b0;
  logic                   pctl = 1'b0;
  logic                   slow = 1'b0;
  logic                   req;
  logic                   alt;
  logic                   acc;
  logic                   rd_seen = 1'b0;
  logic                   req_d = 1'b0;
  logic [7:0]             d;
  wire  logic [7:0]       fe;
  wire  logic             wds;
  int                     starts = 0;
  logic [7:0]             cfg;
  logic [7:0]             evt;
  logic [7:0]             rd_q[$];
  logic                   note_q[$];
  int                     fail_count = 0;
  int                     num_checks = 0;
  int                     cyc = 0;

  vee_event_enable dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sense_i(sense),
    .session_valid_watchdog_i(sess), .resume_k_detect_i(resk),
    .id_pullup_control_i(pctl), .rxcmd_request_o(req),
    .rxcmd_alt_int_o(alt), .rxcmd_accept_i(acc),
    .resume_watchdog_run_o(fe[7]), .resume_watchdog_start_o(wds),
    .id_pullup_resistor_o(fe[6]), .accessory_detect_enable_o(fe[5]),
    .a_device_bus_load_enable_o(fe[4]), .series_resistor_present_o(fe[3]),
    .power_switch_cmos_o(fe[2]), .power_switch_open_drain_o(fe[1]),
    .power_switch_active_low_o(fe[0]));
  vee_link_model link (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .slow_i(slow), .rxcmd_request_i(req), .rxcmd_accept_o(acc));

  always #2 clock_i = ~clock_i;

  task automatic check(input string name, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_i);
    reg_write_i = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = v;
    @(negedge clock_i);
    reg_write_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_read_i = 1'b1;
    reg_addr_i = a;
    rd_q.push_back(e);
    @(negedge clock_i);
    reg_read_i = 1'b0;
  endtask : rd

  task automatic toggle(input int i);
    @(negedge clock_i);
    case (i)
      0: sense.battery_level_comparator ^= 1'b1;
      1, 2: sense.supply_monitor_level ^= 1'b1;
      3: sess ^= 1'b1;
      4: sense.accessory_resistor_state ^= 2'b01;
      default: sense.id_open_detect ^= 1'b1;
    endcase
  endtask : toggle

  always @(posedge clock_i)
  begin
    rd_seen <= reg_read_i;
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // Read data is judged against the oldest expected read, new notifications against the oldest note.
  always @(negedge clock_i)
  begin
    if (wds)
      starts++;
    if (rd_seen)
      check("read data", reg_rdata_o, rd_q.pop_front());
    if (req && !req_d)
    begin
      if (note_q.size() == 0)
        check("unexpected note", 8'h01, 8'h00);
      else
        check("alt flag", {7'h0, alt}, {7'h0, note_q.pop_front()});
    end
    req_d = req;
  end

  initial
  begin
    void'($urandom(32'hb4472cac));
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    check("reset outputs", fe, 8'hb8);
    rd(8'h88, 8'h70);
    rd(8'h8b, 8'h40);
    d = 8'($urandom);
    wr(8'h89, d | 8'h24);
    cfg = (8'h70 | d | 8'h24) & 8'h7c;
    d = 8'($urandom);
    wr(8'h8a, d | 8'h20);
    cfg = cfg & ~(d | 8'h20);
    rd(8'h8a, cfg);
    d = 8'($urandom);
    wr(8'h8c, d | 8'h10);
    evt = (8'h50 | d) & 8'h7f;
    d = 8'($urandom);
    wr(8'h8d, d);
    rd(8'h8b, evt & ~d);
    wr(8'h8b, 8'h40);
    resk = 1'b1;
    pctl = 1'b1;
    repeat (8) @(negedge clock_i);
    check("pull-up", {7'h0, fe[6]}, 8'h01);
    resk = 1'b0;
    pctl = 1'b0;
    wr(8'h8d, 8'h40);
    check("watchdog run", {7'h0, fe[7]}, 8'h00);
    resk = 1'b1;
    repeat (8) @(negedge clock_i);
    resk = 1'b0;
    wr(8'h8c, 8'h40);
    rd(8'h8d, 8'h40);
    sense.dp_charger_comparator_state = 1'b1;
    sense.dm_charger_comparator_state = 1'b1;
    repeat (4) @(negedge clock_i);
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom);
      wr(8'h88, (d & 8'hf3) | (8'(k) << 2));
      check("front end", fe, {2'b10, d[6:4], k[0], {2{k == 2}}});
      rd(8'h89, (d & 8'h70) | 8'h03 | (8'(k) << 2));
    end
    for (int i = 0; i < 6; i++)
    begin
      slow = i[0];
      wr(8'h8b, 8'h40 | (8'h01 << i));
      check("pull-up", {7'h0, fe[6]}, {7'h0, i == 4});
      rd(8'h8c, 8'h40 | (8'h01 << i));
      for (int k = 0; k < 2; k++)
      begin
        if (i == 0 || i >= 4 || (i > 1 && k == 0) || (i == 1 && k == 1))
          note_q.push_back(1'b1);
        toggle(i);
        repeat (16) @(negedge clock_i);
        if (i == 4 && k == 0)
          rd(8'h90, 8'h01);
      end
    end
    wr(8'h8b, 8'h40);
    for (int i = 0; i < 6; i++)
    begin
      toggle(i);
      repeat (16) @(negedge clock_i);
    end
    check("notes left", 8'(note_q.size()), 8'h00);
    check("reads left", 8'(rd_q.size()), 8'h00);
    check("watchdog starts", 8'(starts), 8'h01);
    stop_test();
  end
endmodule : test_vee_event_enable
`default_nettype wire

// File: vee_event_enable.sv
// Purpose: Event enable registers and receive-command notification request.
// Assumes: Register port is a simple one-cycle strobe from the ULPI engine.
// Notes:   Sensor inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "vee_map.svh"

// What this block does
// - Resume watchdog enable bit gates the watchdog timer; resets set.
// - Enabled watchdog starts counting on a detected resume K state.
// - Enabled id-open event reports each edge of the id-open detect.
// - Enabled resistor event reports each edge of accessory resistor detection.
// - Every event notification, resistor or other, sends the alternate-interrupt flag.
// - Accessory resistor state is readable in a two-bit status field.
// - Resistor event enable forces the id pull-up on regardless of control.
// - Enabled session event reports each session watchdog timeout.
// - Enabled rise event reports supply monitor low-to-high edges.
// - Enabled fall event reports supply monitor high-to-low edges.
// - Enabled battery monitor reports each debounced comparator edge.
// - Config register has a set alias 0x89 and clear alias 0x8a.
// - Charger comparator status bits are read-only debounced comparator levels.
// - Push-pull bit overrides polarity select and gives CMOS drive.
// - Polarity zero is active-high source; one is active-low open drain.
// - Accessory detect enable permits accessory detection in active mode.
module vee_event_enable (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // Register port
  input  wire logic                  reg_write_i,
  input  wire logic                  reg_read_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic      [7:0]            reg_rdata_o,
  // Analog and timer sensing
  input  wire vee_pkg::vee_sense_type sense_i,
  input  wire logic                  session_valid_watchdog_i,
  input  wire logic                  resume_k_detect_i,
  input  wire logic                  id_pullup_control_i,
  // Receive command request towards the ULPI engine
  output logic                       rxcmd_request_o,
  output logic                       rxcmd_alt_int_o,
  input  wire logic                  rxcmd_accept_i,
  // Controls towards the analog front end
  output logic                       resume_watchdog_run_o,
  output logic                       resume_watchdog_start_o,
  output logic                       id_pullup_resistor_o,
  output logic                       accessory_detect_enable_o,
  output logic                       a_device_bus_load_enable_o,
  output logic                       series_resistor_present_o,
  output logic                       power_switch_cmos_o,
  output logic                       power_switch_open_drain_o,
  output logic                       power_switch_active_low_o
);

  localparam int SENSE_W = $bits(vee_pkg::vee_sense_type);

  vee_pkg::vee_sense_type sync1;
  vee_pkg::vee_sense_type sync2;
  vee_pkg::vee_sense_type last;
  logic [1:0]             tmo_sync;
  logic                   tmo_last;
  logic [1:0]             k_sync;
  logic                   k_last;
  logic [7:0]             cfg;
  logic [7:0]             evt;
  logic                   pend;
  logic                   pend_alt;
  vee_pkg::vee_state_type state;
  logic [7:0]             next_cfg;
  logic [7:0]             next_evt;
  logic                   next_pend;
  logic                   next_pend_alt;
  vee_pkg::vee_state_type next_state;
  logic [7:0]             next_rdata;
  logic                   next_request;
  logic                   next_alt;
  logic                   next_start;
  logic                   hit;
  logic                   hit_alt;

  initial
  begin
    if (SENSE_W != 7)
    begin
      $error("Sense struct width must be seven bits.");
    end
  end

  // Applies a set or clear alias write to the writable bits only.
  function automatic logic [7:0] vee_alias(input logic [7:0] cur,
                                           input logic [7:0] wd,
                                           input logic       set,
                                           input logic [7:0] mask);
    logic [7:0] m;
    m = wd & mask;
    vee_alias = set ? (cur | m) : (cur & ~m);
  endfunction : vee_alias

  // Synchronisers: first stage is read only by the second stage.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1    <= '0;
      sync2    <= '0;
      last     <= '0;
      tmo_sync <= 2'h0;
      tmo_last <= 1'b0;
      k_sync   <= 2'h0;
      k_last   <= 1'b0;
    end
    else
    begin
      sync1    <= sense_i;
      sync2    <= sync1;
      last     <= sync2;
      tmo_sync <= {tmo_sync[0], session_valid_watchdog_i};
      tmo_last <= tmo_sync[1];
      k_sync   <= {k_sync[0], resume_k_detect_i};
      k_last   <= k_sync[1];
    end
  end

  // Event detection, gated by the enable bits.
  always_comb
  begin
    hit = 1'b0;
    hit_alt = 1'b0;
    if (evt[`VEE_EVT_FLOAT_BIT] &&
        (sync2.id_open_detect != last.id_open_detect))
    begin
      hit = 1'b1;
    end
    if (evt[`VEE_EVT_RES_BIT] &&
        (sync2.accessory_resistor_state != last.accessory_resistor_state))
    begin
      hit = 1'b1;
      if (sync2.accessory_resistor_state != 2'h0)
      begin
        hit_alt = 1'b1;
      end
    end
    if (evt[`VEE_EVT_SESS_BIT] && tmo_sync[1] && !tmo_last)
    begin
      hit = 1'b1;
    end
    if (evt[`VEE_EVT_RISE_BIT] &&
        sync2.supply_monitor_level && !last.supply_monitor_level)
    begin
      hit = 1'b1;
    end
    if (evt[`VEE_EVT_FALL_BIT] &&
        !sync2.supply_monitor_level && last.supply_monitor_level)
    begin
      hit = 1'b1;
    end
    if (evt[`VEE_EVT_BATT_BIT] &&
        (sync2.battery_level_comparator != last.battery_level_comparator))
    begin
      hit = 1'b1;
    end
  end

  // Register writes, read data and notification sequencing.
  always_comb
  begin
    next_cfg = cfg;
    next_evt = evt;
    next_rdata = reg_rdata_o;
    next_pend = pend;
    next_pend_alt = pend_alt;
    next_state = state;
    next_request = rxcmd_request_o;
    next_alt = rxcmd_alt_int_o;
    next_start = evt[`VEE_EVT_RESUME_BIT] && k_sync[1] && !k_last;
    if (reg_write_i)
    begin
      case (reg_addr_i)
        `VEE_CFG_ADDR:
          next_cfg = (cfg & ~`VEE_CFG_RW_MASK) |
                     (reg_wdata_i & `VEE_CFG_RW_MASK);
        `VEE_CFG_SET_ADDR:
          next_cfg = vee_alias(cfg, reg_wdata_i, 1'b1,
                               `VEE_CFG_RW_MASK);
        `VEE_CFG_CLR_ADDR:
          next_cfg = vee_alias(cfg, reg_wdata_i, 1'b0,
                               `VEE_CFG_RW_MASK);
        `VEE_EVT_ADDR:
          next_evt = reg_wdata_i & `VEE_EVT_RW_MASK;
        `VEE_EVT_SET_ADDR:
          next_evt = vee_alias(evt, reg_wdata_i, 1'b1, `VEE_EVT_RW_MASK);
        `VEE_EVT_CLR_ADDR:
          next_evt = vee_alias(evt, reg_wdata_i, 1'b0, `VEE_EVT_RW_MASK);
        default:
          next_cfg = cfg;
      endcase
    end
    // Status bits always track the debounced comparators.
    next_cfg[`VEE_CFG_DP_BIT] = sync2.dp_charger_comparator_state;
    next_cfg[`VEE_CFG_DM_BIT] = sync2.dm_charger_comparator_state;
    if (reg_read_i)
    begin
      case (reg_addr_i)
        `VEE_CFG_ADDR, `VEE_CFG_SET_ADDR, `VEE_CFG_CLR_ADDR:
          next_rdata = cfg;
        `VEE_EVT_ADDR, `VEE_EVT_SET_ADDR, `VEE_EVT_CLR_ADDR:
          next_rdata = evt;
        default:
          next_rdata = {6'h00, sync2.accessory_resistor_state};
      endcase
    end
    // A new event merges into a pending one so none is lost.
    if (hit)
    begin
      next_pend = 1'b1;
      next_pend_alt = pend_alt | hit_alt;
    end
    case (state)
      vee_pkg::VEE_IDLE:
        if (pend)
        begin
          next_state = vee_pkg::VEE_SEND;
          next_request = 1'b1;
          next_alt = 1'b1;
          next_pend = hit;
          next_pend_alt = hit_alt;
        end
      vee_pkg::VEE_SEND:
        if (rxcmd_accept_i)
        begin
          next_state = vee_pkg::VEE_WAIT;
          next_request = 1'b0;
          next_alt = 1'b0;
        end
      vee_pkg::VEE_WAIT:
        next_state = vee_pkg::VEE_IDLE;
      default:
        next_state = vee_pkg::VEE_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg                     <= `VEE_CFG_RESET;
      evt                     <= `VEE_EVT_RESET;
      pend                    <= 1'b0;
      pend_alt                <= 1'b0;
      state                   <= vee_pkg::VEE_IDLE;
      reg_rdata_o             <= 8'h00;
      rxcmd_request_o         <= 1'b0;
      rxcmd_alt_int_o         <= 1'b0;
      resume_watchdog_start_o <= 1'b0;
    end
    else
    begin
      cfg                     <= next_cfg;
      evt                     <= next_evt;
      pend                    <= next_pend;
      pend_alt                <= next_pend_alt;
      state                   <= next_state;
      reg_rdata_o             <= next_rdata;
      rxcmd_request_o         <= next_request;
      rxcmd_alt_int_o         <= next_alt;
      resume_watchdog_start_o <= next_start;
    end
  end

  // Front-end controls registered from the next register values.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      resume_watchdog_run_o      <= 1'b1;
      id_pullup_resistor_o       <= 1'b0;
      accessory_detect_enable_o  <= 1'b1;
      a_device_bus_load_enable_o <= 1'b1;
      series_resistor_present_o  <= 1'b1;
      power_switch_cmos_o        <= 1'b0;
      power_switch_open_drain_o  <= 1'b0;
      power_switch_active_low_o  <= 1'b0;
    end
    else
    begin
      resume_watchdog_run_o      <= next_evt[`VEE_EVT_RESUME_BIT];
      id_pullup_resistor_o       <= next_evt[`VEE_EVT_RES_BIT] ||
                                    id_pullup_control_i;
      accessory_detect_enable_o  <= next_cfg[`VEE_CFG_ACA_BIT];
      a_device_bus_load_enable_o <= next_cfg[`VEE_CFG_LOAD_BIT];
      series_resistor_present_o  <= next_cfg[`VEE_CFG_SERIES_BIT];
      power_switch_cmos_o        <= next_cfg[`VEE_CFG_CMOS_BIT];
      power_switch_open_drain_o  <= !next_cfg[`VEE_CFG_CMOS_BIT] &&
                                    next_cfg[`VEE_CFG_POL_BIT];
      power_switch_active_low_o  <= !next_cfg[`VEE_CFG_CMOS_BIT] &&
                                    next_cfg[`VEE_CFG_POL_BIT];
    end
  end

endmodule : vee_event_enable
`default_nettype wire

// File: vee_event_enable_chk.sv
// Purpose: Port assertions for the event enable block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module vee_event_enable_chk (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       resume_k_detect_i,
  input wire logic       rxcmd_request_o,
  input wire logic       rxcmd_alt_int_o,
  input wire logic       rxcmd_accept_i,
  input wire logic       resume_watchdog_run_o,
  input wire logic       resume_watchdog_start_o,
  input wire logic       id_pullup_resistor_o,
  input wire logic       a_device_bus_load_enable_o,
  input wire logic       power_switch_cmos_o,
  input wire logic       power_switch_open_drain_o,
  input wire logic       power_switch_active_low_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_run_clear: assert property (
    reg_write_i && reg_addr_i == 8'h8d && reg_wdata_i[6]
    |=> !resume_watchdog_run_o) else $error("watchdog run not cleared");
  a_start_k: assert property (
    $rose(resume_k_detect_i) && resume_watchdog_run_o
    |-> ##[1:5] resume_watchdog_start_o) else $error("no watchdog start");
  a_start_pulse: assert property (
    resume_watchdog_start_o |=> !resume_watchdog_start_o)
    else $error("watchdog start too long");
  a_alt_flag: assert property (
    rxcmd_request_o |-> rxcmd_alt_int_o) else $error("alt flag missing");
  a_req_hold: assert property (
    rxcmd_request_o && !rxcmd_accept_i |=> rxcmd_request_o)
    else $error("request dropped early");
  a_req_gap: assert property (
    rxcmd_request_o && rxcmd_accept_i |=> !rxcmd_request_o [*2])
    else $error("request gap too short");
  a_pull_force: assert property (
    reg_write_i && reg_addr_i == 8'h8c && reg_wdata_i[4]
    |-> ##2 id_pullup_resistor_o) else $error("pull-up not forced");
  a_cmos_wins: assert property (
    power_switch_cmos_o |-> !power_switch_open_drain_o &&
    !power_switch_active_low_o) else $error("push-pull not overriding");
  a_od_mode: assert property (
    reg_write_i && reg_addr_i == 8'h88 && reg_wdata_i[3:2] == 2'b10
    |=> power_switch_open_drain_o && power_switch_active_low_o)
    else $error("open drain mode missing");
  a_cfg_set: assert property (
    reg_write_i && reg_addr_i == 8'h89 && reg_wdata_i[2]
    |=> power_switch_cmos_o) else $error("set alias failed");
  a_cfg_clr: assert property (
    reg_write_i && reg_addr_i == 8'h8a && reg_wdata_i[5]
    |=> !a_device_bus_load_enable_o) else $error("clear alias failed");
endmodule : vee_event_enable_chk
`default_nettype wire

bind vee_event_enable vee_event_enable_chk chk (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .resume_k_detect_i(resume_k_detect_i),
  .rxcmd_request_o(rxcmd_request_o), .rxcmd_alt_int_o(rxcmd_alt_int_o),
  .rxcmd_accept_i(rxcmd_accept_i),
  .resume_watchdog_run_o(resume_watchdog_run_o),
  .resume_watchdog_start_o(resume_watchdog_start_o),
  .id_pullup_resistor_o(id_pullup_resistor_o),
  .a_device_bus_load_enable_o(a_device_bus_load_enable_o),
  .power_switch_cmos_o(power_switch_cmos_o),
  .power_switch_open_drain_o(power_switch_open_drain_o),
  .power_switch_active_low_o(power_switch_active_low_o));

// File: vee_link_model.sv
// Purpose: Link side of the receive command request, taking each request.
// Assumes: Accept is a one-cycle pulse, same clock as the block.
// Notes:   slow_i stretches the wait before accepting from two to six cycles.
`timescale 1ns/1ps
`default_nettype none
module vee_link_model (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Request handshake
  input  wire logic slow_i,
  input  wire logic rxcmd_request_i,
  output logic      rxcmd_accept_o
);
  logic [2:0] wait_cnt;
  logic [2:0] next_wait_cnt;
  logic       next_accept;

  always_comb
  begin
    next_wait_cnt = wait_cnt;
    next_accept   = 1'b0;
    if (rxcmd_request_i && !rxcmd_accept_o)
    begin
      if (wait_cnt == (slow_i ? 3'h5 : 3'h1))
      begin
        next_accept   = 1'b1;
        next_wait_cnt = 3'h0;
      end
      else
      begin
        next_wait_cnt = wait_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_cnt       <= 3'h0;
      rxcmd_accept_o <= 1'b0;
    end
    else
    begin
      wait_cnt       <= next_wait_cnt;
      rxcmd_accept_o <= next_accept;
    end
  end
endmodule : vee_link_model
`default_nettype wire

// File: vee_map.svh
// Purpose: Register offsets, field positions, reset values of the event block.
// Assumes: Byte-wide registers on the transceiver register port.
// Notes:   Included by the top module only.
`ifndef VEE_MAP_SVH
`define VEE_MAP_SVH
`define VEE_CFG_ADDR        8'h88
`define VEE_CFG_SET_ADDR    8'h89
`define VEE_CFG_CLR_ADDR    8'h8a
`define VEE_EVT_ADDR        8'h8b
`define VEE_EVT_SET_ADDR    8'h8c
`define VEE_EVT_CLR_ADDR    8'h8d
`define VEE_CFG_RESET       8'h70
`define VEE_EVT_RESET       8'h40
`define VEE_CFG_RW_MASK     8'h7c
`define VEE_EVT_RW_MASK     8'h7f
`define VEE_CFG_DM_BIT      0
`define VEE_CFG_DP_BIT      1
`define VEE_CFG_CMOS_BIT    2
`define VEE_CFG_POL_BIT     3
`define VEE_CFG_SERIES_BIT  4
`define VEE_CFG_LOAD_BIT    5
`define VEE_CFG_ACA_BIT     6
`define VEE_EVT_BATT_BIT    0
`define VEE_EVT_FALL_BIT    1
`define VEE_EVT_RISE_BIT    2
`define VEE_EVT_SESS_BIT    3
`define VEE_EVT_RES_BIT     4
`define VEE_EVT_FLOAT_BIT   5
`define VEE_EVT_RESUME_BIT  6
`endif

// File: vee_pkg.sv
// Purpose: Types shared by the event enable block.
// Assumes: Offsets and fields come from vee_map.svh.
// Notes:   Sensor levels travel as one packed struct.
package vee_pkg;
  typedef struct packed {
    logic       id_open_detect;
    logic [1:0] accessory_resistor_state;
    logic       supply_monitor_level;
    logic       battery_level_comparator;
    logic       dp_charger_comparator_state;
    logic       dm_charger_comparator_state;
  } vee_sense_type;

  typedef struct packed {
    logic       valid;
    logic       alt_int;
  } vee_note_type;

  typedef enum logic [1:0] {
    VEE_IDLE,
    VEE_SEND,
    VEE_WAIT
  } vee_state_type;
endpackage : vee_pkg
